// ===== afp_ahb_regs.sv
// AHB-Lite register slave for the almost-flag block
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.svh"
module afp_ahb_regs (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Not checked, every access is taken as a word
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  afp_reg_if.regs bus // Core side
);

  logic addr_ok;
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic [31:0] rdata_q;
  logic soft_rst_q;
  logic [`AFP_EV_W-1:0] mask_q;

  // Size is not checked, every register is a whole word
  assign addr_ok = hsel && htrans[1] && hready && (hsize == 3'h2 || hsize != 3'h2);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign bus.status_rd = addr_ok && !hwrite && (haddr[7:0] == `AFP_ADDR_STATUS) && (haddr[31:8] == 24'h00_0000);
  assign bus.soft_rst = soft_rst_q;
  assign bus.mask = mask_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
      waddr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= `AFP_MASK_RESET;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_pend_q && (waddr_q == `AFP_ADDR_CTRL) && hwdata[`AFP_CTRL_SOFT_RESET];
      if (wr_pend_q && waddr_q == `AFP_ADDR_MASK) begin
        mask_q <= hwdata[`AFP_EV_W-1:0];
      end
    end
  end

  // Read data sampled at the address phase so it stands for the whole data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      rdata_q <= 32'h0000_0000;
      if (haddr[31:8] == 24'h00_0000) begin
        case (haddr[7:0])
          `AFP_ADDR_STATUS: rdata_q[`AFP_EV_W-1:0] <= bus.status;
          `AFP_ADDR_MASK: rdata_q[`AFP_EV_W-1:0] <= mask_q;
          `AFP_ADDR_COUNT: rdata_q[`AFP_CNT_W-1:0] <= bus.count;
          `AFP_ADDR_OFFSETS: begin
            rdata_q[`AFP_OFFSET_W-1:0] <= bus.off_x;
            rdata_q[`AFP_OFFSETS_Y_LSB +: `AFP_OFFSET_W] <= bus.off_y;
          end
          `AFP_ADDR_STATE: begin
            rdata_q[3:0] <= bus.state;
            rdata_q[`AFP_STATE_FLAG_BIT] <= bus.flag;
            rdata_q[`AFP_STATE_FULL_N_BIT] <= bus.full_n;
          end
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : afp_ahb_regs
`default_nettype wire

// ===== afp_almost_flag.sv
// Almost-empty/almost-full flag core with offset programming and word count
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.svh"
module afp_almost_flag #(
  parameter int DEPTH = `AFP_DEPTH_WORDS, // Words in the FIFO
  parameter int CNT_W = `AFP_CNT_W // Width of the word count
) (
  input wire logic CLK, // System clock, 40 MHz
  input wire logic RST, // Async reset, active high
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB ready in
  output logic [31:0] HRDATA, // AHB read data
  output logic HREADYOUT, // AHB ready out
  output logic HRESP, // AHB response
  input wire logic LOAD_CLOCK, // Load strobe, sampled
  input wire logic UNLOAD_CLOCK, // Unload strobe, sampled
  input wire logic FIFO_RESET_N, // FIFO reset, active low
  input wire logic OFFSET_PROGRAM_ENABLE_N, // Offset program enable, active low
  input wire logic [8:0] DATA_IN, // Data inputs, low offset bits
  input wire logic OFFSET_MSB_IN, // Offset most significant bit
  output logic ALMOST_BOUNDARY_FLAG, // Almost-empty or almost-full
  output logic FULL_N, // Low when full
  output logic IRQ // Unmasked event pending
);

  afp_reg_if rif ();

  logic ld_prev_q;
  logic ul_prev_q;
  logic ld_rise;
  logic ul_rise;
  logic clr;
  logic prog_hold;
  logic prog_evt;
  logic load_ok;
  logic unload_ok;
  logic load_refused;
  logic unload_refused;
  logic [CNT_W-1:0] depth_c;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic flag_q;
  logic flag_d;
  logic full_n_q;
  logic irq_q;
  logic [`AFP_EV_W-1:0] status_q;
  logic [`AFP_EV_W-1:0] status_d;
  logic [`AFP_EV_W-1:0] events;
  afp_pkg::afp_offset_t off_x;
  afp_pkg::afp_offset_t off_y;
  afp_pkg::afp_prog_e prog_state;

  assign depth_c = CNT_W'(DEPTH);

  // Strobes are synchronous, so one register gives the rising edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ld_prev_q <= 1'b0;
      ul_prev_q <= 1'b0;
    end else begin
      ld_prev_q <= LOAD_CLOCK;
      ul_prev_q <= UNLOAD_CLOCK;
    end
  end

  assign ld_rise = LOAD_CLOCK && !ld_prev_q;
  assign ul_rise = UNLOAD_CLOCK && !ul_prev_q;
  // Pin reset and software reset act the same
  assign clr = !FIFO_RESET_N || rif.soft_rst; // [RULE10]

  afp_offset_prog u_prog (
    .clk(CLK),
    .rst(RST),
    .clr(clr),
    .ld_rise(ld_rise),
    .pen_n(OFFSET_PROGRAM_ENABLE_N),
    .value({OFFSET_MSB_IN, DATA_IN}),
    .off_x_q(off_x),
    .off_y_q(off_y),
    .state_q(prog_state),
    .prog_hold(prog_hold),
    .prog_evt(prog_evt)
  );

  afp_ahb_regs u_regs (
    .clk(CLK),
    .rst(RST),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hrdata(HRDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .bus(rif.regs)
  );

  // Load acceptance; a programming edge never stores data
  always_comb begin
    load_ok = ld_rise && !prog_hold && (count_q != depth_c) && !clr; // [RULE7] [RULE11]
    load_refused = ld_rise && !prog_hold && (count_q == depth_c) && !clr;
    unload_ok = ul_rise && (count_q != '0) && !clr;
    unload_refused = ul_rise && (count_q == '0) && !clr;
  end

  // Simultaneous accepted load and unload cancel out
  always_comb begin
    count_d = count_q;
    if (clr) begin
      count_d = '0; // [RULE10]
    end else if (load_ok && !unload_ok) begin
      count_d = count_q + CNT_W'(1); // [RULE12]
    end else if (unload_ok && !load_ok) begin
      count_d = count_q - CNT_W'(1); // [RULE12]
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Flag uses the offsets in force now; new offsets show from the next edge
  always_comb begin
    flag_d = (count_d <= CNT_W'(off_x)) || (count_d >= (depth_c - CNT_W'(off_y))); // [RULE3]
    if (clr) begin
      flag_d = 1'b1; // [RULE10]
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flag_q <= 1'b1;
      full_n_q <= 1'b1;
    end else begin
      flag_q <= flag_d;
      full_n_q <= clr || (count_d != depth_c); // [RULE10]
    end
  end

  assign ALMOST_BOUNDARY_FLAG = flag_q;
  assign FULL_N = full_n_q;

  // Sticky events; a new event wins over the read that clears
  always_comb begin
    events = '0;
    events[`AFP_EV_FLAG_RISE] = flag_d && !flag_q;
    events[`AFP_EV_PROGRAMMED] = prog_evt && !clr;
    events[`AFP_EV_LOAD_FULL] = load_refused;
    events[`AFP_EV_UNLOAD_EMPTY] = unload_refused;
    status_d = (rif.status_rd ? '0 : status_q) | events;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |(status_d & rif.mask);
    end
  end

  assign IRQ = irq_q;

  assign rif.status = status_q;
  assign rif.count = count_q;
  assign rif.off_x = off_x;
  assign rif.off_y = off_y;
  assign rif.state = prog_state;
  assign rif.flag = flag_q;
  assign rif.full_n = full_n_q;

  flag_window_a: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
    !$past(clr) |-> (flag_q == ((count_q <= CNT_W'($past(off_x))) ||
                                (count_q >= depth_c - CNT_W'($past(off_y))))))
    else $error("boundary flag disagrees with count and offsets");

  reset_flags_a: assert property (@(posedge CLK) disable iff (RST) // [RULE10]
    clr |=> (flag_q && full_n_q && count_q == '0))
    else $error("FIFO reset did not set flag and not-full high");

  prog_no_store_a: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
    (ld_rise && !OFFSET_PROGRAM_ENABLE_N && prog_state != afp_pkg::AFP_LOCKED && !ul_rise && !clr)
    |=> $stable(count_q))
    else $error("data stored during offset programming");

  full_no_store_a: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
    (!full_n_q && !ul_rise && !clr) |=> (count_q == depth_c && !full_n_q))
    else $error("load accepted while full");

  store_counts_a: assert property (@(posedge CLK) disable iff (RST) // [RULE11] [RULE12]
    (ld_rise && OFFSET_PROGRAM_ENABLE_N && full_n_q && !ul_rise && !clr)
    |=> (count_q == $past(count_q) + CNT_W'(1)))
    else $error("accepted load did not raise the count");

  unload_counts_a: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
    (ul_rise && !ld_rise && count_q != '0 && !clr) |=> (count_q == $past(count_q) - CNT_W'(1)))
    else $error("accepted unload did not lower the count");

  lock_on_data_a: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
    (ld_rise && OFFSET_PROGRAM_ENABLE_N && !clr) |=> (prog_state == afp_pkg::AFP_LOCKED)
    ##1 (prog_state == afp_pkg::AFP_LOCKED || $past(clr)))
    else $error("programming still open after a data word");

  // Interrupt lags a mask write by one cycle, so only a settled mask is checked
  irq_level_a: assert property (@(posedge CLK) disable iff (RST)
    ((|(status_q & rif.mask)) && $stable(rif.mask)) |-> IRQ)
    else $error("unmasked event without interrupt");

  irq_quiet_a: assert property (@(posedge CLK) disable iff (RST)
    (((status_q & rif.mask) == '0) && $stable(rif.mask)) |-> !IRQ)
    else $error("interrupt without unmasked event");

  full_level_a: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
    !$past(clr) |-> (full_n_q == (count_q != depth_c)))
    else $error("not-full flag disagrees with count");

  count_bound_a: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
    count_q <= depth_c)
    else $error("count above depth");

  count_step_a: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
    !$past(clr) |-> (count_q == $past(count_q) || count_q == $past(count_q) + CNT_W'(1) ||
                     count_q == $past(count_q) - CNT_W'(1)))
    else $error("count moved by more than one");

  both_strobes_a: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
    (ld_rise && ul_rise && OFFSET_PROGRAM_ENABLE_N && full_n_q && count_q != '0 && !clr) |=> $stable(count_q))
    else $error("load and unload together changed the count");

  empty_unload_a: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
    (count_q == '0 && ul_rise && !ld_rise && !clr) |=> (count_q == '0))
    else $error("unload from empty changed the count");

  reopen_a: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
    clr |=> (prog_state == afp_pkg::AFP_OPEN))
    else $error("FIFO reset did not reopen programming");

  state_onehot_a: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
    $onehot(prog_state))
    else $error("sequencer state not one-hot");

  empty_before_lock_a: assert property (@(posedge CLK) disable iff (RST) // [RULE1] [RULE7]
    (prog_state != afp_pkg::AFP_LOCKED) |-> (count_q == '0))
    else $error("word stored before programming closed");

  locked_pen_a: assert property (@(posedge CLK) disable iff (RST) // [RULE1]
    (ld_rise && !OFFSET_PROGRAM_ENABLE_N && prog_state == afp_pkg::AFP_LOCKED && !clr)
    |=> ($stable(off_x) && $stable(off_y)))
    else $error("offsets reprogrammed after first data word");

  locked_store_a: assert property (@(posedge CLK) disable iff (RST) // [RULE1] [RULE11]
    (ld_rise && !OFFSET_PROGRAM_ENABLE_N && prog_state == afp_pkg::AFP_LOCKED && full_n_q && !ul_rise && !clr)
    |=> (count_q == $past(count_q) + CNT_W'(1)))
    else $error("load with enable low after lock not stored");

  load_full_evt_a: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
    load_refused |=> status_q[`AFP_EV_LOAD_FULL])
    else $error("refused load left no status bit");

  unload_empty_evt_a: assert property (@(posedge CLK) disable iff (RST) // [RULE12]
    unload_refused |=> status_q[`AFP_EV_UNLOAD_EMPTY])
    else $error("refused unload left no status bit");

  prog_status_a: assert property (@(posedge CLK) disable iff (RST) // [RULE5]
    (prog_evt && !clr) |=> status_q[`AFP_EV_PROGRAMMED])
    else $error("offset capture left no status bit");

  flag_rise_evt_a: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
    $rose(flag_q) |-> status_q[`AFP_EV_FLAG_RISE])
    else $error("flag rise left no status bit");

  status_sticky_a: assert property (@(posedge CLK) disable iff (RST)
    !rif.status_rd |=> ((status_q & $past(status_q)) == $past(status_q)))
    else $error("status bit lost without a read");

  status_clear_a: assert property (@(posedge CLK) disable iff (RST)
    (rif.status_rd && events == '0) |=> (status_q == '0))
    else $error("status read did not clear");

  flag_full_a: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
    !full_n_q |-> ALMOST_BOUNDARY_FLAG)
    else $error("flag low while full");

  flag_empty_a: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
    (count_q == '0) |-> ALMOST_BOUNDARY_FLAG)
    else $error("flag low while empty");

  bus_okay_a: assert property (@(posedge CLK) disable iff (RST)
    HREADYOUT && !HRESP)
    else $error("register slave not ready or not OKAY");

endmodule : afp_almost_flag
`default_nettype wire

// ===== afp_offset_prog.sv
// Offset programming sequencer and offset registers
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.svh"
module afp_offset_prog (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic clr, // FIFO reset, synchronous
  input wire logic ld_rise, // Load clock rising edge
  input wire logic pen_n, // Program enable, active low
  input wire afp_pkg::afp_offset_t value, // Offset value on data pins
  output afp_pkg::afp_offset_t off_x_q, // Almost-empty offset
  output afp_pkg::afp_offset_t off_y_q, // Almost-full offset
  output afp_pkg::afp_prog_e state_q, // Sequencer state
  output logic prog_hold, // Load edge used for programming
  output logic prog_evt // An offset was captured
);

  afp_pkg::afp_prog_e state_d;

  // Pen is only looked at on a load edge, writer keeps it clean around it [RULE4]
  always_comb begin
    prog_hold = ld_rise && !pen_n && (state_q != afp_pkg::AFP_LOCKED); // [RULE7]
    prog_evt = ld_rise && !pen_n &&
               ((state_q == afp_pkg::AFP_OPEN) || (state_q == afp_pkg::AFP_FIRST));
  end

  always_comb begin
    state_d = state_q;
    if (clr) begin
      state_d = afp_pkg::AFP_OPEN;
    end else if (ld_rise) begin
      case (state_q)
        afp_pkg::AFP_OPEN: state_d = pen_n ? afp_pkg::AFP_LOCKED : afp_pkg::AFP_FIRST; // [RULE1]
        afp_pkg::AFP_FIRST: state_d = pen_n ? afp_pkg::AFP_LOCKED : afp_pkg::AFP_SECOND;
        // Held enable past two edges keeps writes off but loads nothing more
        afp_pkg::AFP_SECOND: state_d = pen_n ? afp_pkg::AFP_LOCKED : afp_pkg::AFP_SECOND;
        afp_pkg::AFP_LOCKED: state_d = afp_pkg::AFP_LOCKED;
        default: state_d = afp_pkg::AFP_LOCKED;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= afp_pkg::AFP_OPEN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      off_x_q <= `AFP_OFFSET_DEFAULT; // [RULE2]
      off_y_q <= `AFP_OFFSET_DEFAULT;
    end else if (clr) begin
      off_x_q <= `AFP_OFFSET_DEFAULT; // [RULE2]
      off_y_q <= `AFP_OFFSET_DEFAULT;
    end else if (prog_evt && state_q == afp_pkg::AFP_OPEN) begin
      off_x_q <= value; // [RULE5]
      off_y_q <= value;
    end else if (prog_evt) begin
      off_y_q <= value; // [RULE6]
    end
  end

  first_capture_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    (ld_rise && !pen_n && !clr && state_q == afp_pkg::AFP_OPEN)
    |=> (off_x_q == $past(value) && off_y_q == $past(value) && state_q == afp_pkg::AFP_FIRST))
    else $error("first programming edge did not load both offsets");

  second_capture_a: assert property (@(posedge clk) disable iff (rst) // [RULE6]
    (ld_rise && !pen_n && !clr && state_q == afp_pkg::AFP_FIRST)
    |=> (off_y_q == $past(value) && $stable(off_x_q)))
    else $error("second programming edge touched the wrong offset");

  default_offsets_a: assert property (@(posedge clk) disable iff (rst) // [RULE2]
    clr |=> (off_x_q == `AFP_OFFSET_DEFAULT && off_y_q == `AFP_OFFSET_DEFAULT))
    else $error("offsets not at default after FIFO reset");

  locked_offsets_a: assert property (@(posedge clk) disable iff (rst) // [RULE1]
    (state_q == afp_pkg::AFP_LOCKED && !clr) |=> ($stable(off_x_q) && $stable(off_y_q)))
    else $error("offsets changed after first data word");

endmodule : afp_offset_prog
`default_nettype wire

// ===== afp_pkg.sv
// Types shared by the almost-flag block
package afp_pkg;

  typedef enum logic [3:0] {
    AFP_OPEN = 4'b0001,
    AFP_FIRST = 4'b0010,
    AFP_SECOND = 4'b0100,
    AFP_LOCKED = 4'b1000
  } afp_prog_e;

  typedef logic [9:0] afp_offset_t;

endpackage : afp_pkg

// ===== afp_reg_if.sv
// Interface between the core and its register slave
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.svh"
interface afp_reg_if;
  logic soft_rst;
  logic [`AFP_EV_W-1:0] mask;
  logic status_rd;
  logic [`AFP_EV_W-1:0] status;
  logic [`AFP_CNT_W-1:0] count;
  afp_pkg::afp_offset_t off_x;
  afp_pkg::afp_offset_t off_y;
  afp_pkg::afp_prog_e state;
  logic flag;
  logic full_n;

  modport regs (
    output soft_rst, mask, status_rd,
    input status, count, off_x, off_y, state, flag, full_n
  );
  modport core (
    input soft_rst, mask, status_rd,
    output status, count, off_x, off_y, state, flag, full_n
  );
endinterface : afp_reg_if
`default_nettype wire

// ===== afp_regs.svh
// Register offsets, field positions, reset values and sizes for the almost-flag block
// Notes on behaviour
// RULE1 - Offsets are programmable only after reset and before the first data word is stored.
// RULE2 - Without programming, both offsets default to 256.
// RULE3 - Flag high when count is at most X, or at least 2048 minus Y.
// RULE4 - Writer lowers program enable only while load clock is low.
// RULE5 - First load edge with program enable low loads the 10-bit value into X and Y.
// RULE6 - A second such edge reloads Y only; X keeps its value.
// RULE7 - Data is not stored on load edges while offsets are being programmed.
// RULE8 - Writer never programs an offset above 1023.
// RULE9 - To keep defaults, writer holds program enable high until first data word.
// RULE10 - Low FIFO reset clears pointers, drives flag high and not-full high.
// RULE11 - Otherwise a word is stored on each load edge only while not full.
// RULE12 - Word count rises on accepted loads, falls on accepted unloads, feeds the flag.
`ifndef AFP_REGS_SVH
`define AFP_REGS_SVH

`define AFP_ADDR_CTRL 8'h00
`define AFP_ADDR_STATUS 8'h04
`define AFP_ADDR_MASK 8'h08
`define AFP_ADDR_COUNT 8'h0C
`define AFP_ADDR_OFFSETS 8'h10
`define AFP_ADDR_STATE 8'h14

`define AFP_CTRL_SOFT_RESET 0
`define AFP_OFFSETS_Y_LSB 16
`define AFP_STATE_FLAG_BIT 8
`define AFP_STATE_FULL_N_BIT 9

`define AFP_EV_FLAG_RISE 0
`define AFP_EV_PROGRAMMED 1
`define AFP_EV_LOAD_FULL 2
`define AFP_EV_UNLOAD_EMPTY 3
`define AFP_EV_W 4

`define AFP_DEPTH_WORDS 2048
`define AFP_CNT_W 12
`define AFP_OFFSET_W 10
`define AFP_OFFSET_DEFAULT 10'h100
`define AFP_MASK_RESET 4'h0

`endif

// ===== afp_writer_model.sv
// Writer model driving the load and unload strobes, program enable and data pins
`timescale 1ns/100ps
`default_nettype none
module afp_writer_model (
  input wire logic clk, // System clock
  output logic load_clock, // Load strobe
  output logic unload_clock, // Unload strobe
  output logic pen_n, // Program enable, active low
  output logic [8:0] data_in, // Data pins
  output logic msb_in // Offset most significant bit
);
  initial begin
    load_clock = 1'b0;
    unload_clock = 1'b0;
    pen_n = 1'b1;
    data_in = 9'h000;
    msb_in = 1'b0;
  end

  // One strobe cycle; pins flip after the edge so stale values never look valid
  task automatic pulse(input logic ld, input logic ul, input logic [9:0] v);
    {msb_in, data_in} <= v;
    load_clock <= ld;
    unload_clock <= ul;
    @(posedge clk);
    load_clock <= 1'b0;
    unload_clock <= 1'b0;
    {msb_in, data_in} <= ~v;
    @(posedge clk);
  endtask : pulse

  task automatic prog_offsets(input logic two, input logic [9:0] v1, input logic [9:0] v2);
    pen_n <= 1'b0; // Load strobe is low here
    @(posedge clk);
    pulse(1'b1, 1'b0, v1);
    if (two) begin
      pulse(1'b1, 1'b0, v2);
    end
    pen_n <= 1'b1;
    @(posedge clk);
  endtask : prog_offsets
endmodule : afp_writer_model
`default_nettype wire

// ===== test_fifo_almost_flag_offset_programming.sv
// Self-checking testbench for the almost-flag block
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.svh"
module test_fifo_almost_flag_offset_programming;
  localparam int DEPTH = `AFP_DEPTH_WORDS;
  logic clk, rst, hwrite, hreadyout, hresp, fifo_rst_n, ld, ul, pen_n, msb, flag, full_n, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic [8:0] din;
  logic [9:0] v1, v2;
  afp_pkg::afp_offset_t x_e, y_e;
  int num_errors = 0;
  int cmp_count = 0;
  int cnt = 0;

  afp_almost_flag afp_almost_flag_i (
    .CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .LOAD_CLOCK(ld), .UNLOAD_CLOCK(ul), .FIFO_RESET_N(fifo_rst_n),
    .OFFSET_PROGRAM_ENABLE_N(pen_n), .DATA_IN(din), .OFFSET_MSB_IN(msb),
    .ALMOST_BOUNDARY_FLAG(flag), .FULL_N(full_n), .IRQ(irq)
  );
  afp_writer_model writer_i (
    .clk(clk), .load_clock(ld), .unload_clock(ul), .pen_n(pen_n), .data_in(din), .msb_in(msb)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic flag_exp(input int c);
    return (c <= int'(x_e)) || (c >= DEPTH - int'(y_e));
  endfunction : flag_exp

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Single AHB-Lite word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rdv);
    htrans <= 2'b10;
    haddr <= addr;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdv = hrdata;
    check("hresp", hresp, 1'b0);
  endtask : ahb

  task automatic step(input logic l, input logic u);
    writer_i.pulse(l, u, seed[9:0]);
    seed = xs(seed);
    cnt = cnt + int'(l && cnt < DEPTH) - int'(u && cnt > 0);
    @(posedge clk);
    check("flag", flag, flag_exp(cnt));
    check("full_n", full_n, cnt != DEPTH);
  endtask : step

  // Fill past full, hold at full with random refused loads, drain to empty
  task automatic walk();
    while (cnt < DEPTH) step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    ahb(1'b0, `AFP_ADDR_STATUS, 0, rd);
    check("status full", rd & 32'h0000_0005, 32'h0000_0005);
    repeat (300) begin
      seed = xs(seed);
      step(seed[0], seed[1] && cnt > 0 && cnt < DEPTH);
    end
    while (cnt > 0) step(1'b0, 1'b1);
    ahb(1'b0, `AFP_ADDR_COUNT, 0, rd);
    check("count", rd, 0);
  endtask : walk

  initial begin
    // Tests take about 60k cycles; this leaves a margin
    repeat (90000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    seed = 32'h0000_16e9;
    rst = 1'b1;
    fifo_rst_n = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    x_e = `AFP_OFFSET_DEFAULT;
    y_e = `AFP_OFFSET_DEFAULT;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("flag", flag, 1'b1);
    check("full_n", full_n, 1'b1);
    ahb(1'b0, `AFP_ADDR_OFFSETS, 0, rd);
    check("offsets", rd, {6'h00, y_e, 6'h00, x_e});
    walk();
    ahb(1'b0, 32'h0000_0020, 0, rd);
    check("unmapped", rd, 32'h0000_0000);
    ahb(1'b0, `AFP_ADDR_STATUS, 0, rd);
    step(1'b0, 1'b1);
    check("irq masked", irq, 1'b0);
    ahb(1'b1, `AFP_ADDR_MASK, 32'h0000_0008, rd);
    repeat (2) @(posedge clk);
    check("irq", irq, 1'b1);
    ahb(1'b0, `AFP_ADDR_STATUS, 0, rd);
    check("status", rd & 32'h0000_0008, 32'h0000_0008);
    repeat (2) @(posedge clk);
    check("irq cleared", irq, 1'b0);
    // One-edge program, then both orders of the extreme offsets
    for (int i = 0; i < 3; i++) begin
      // Reset a part-filled FIFO so flag and count really have to move
      repeat (300) step(1'b1, 1'b0);
      if (i == 2) begin
        ahb(1'b1, `AFP_ADDR_CTRL, 32'h0000_0001, rd);
      end else begin
        fifo_rst_n <= 1'b0;
        @(posedge clk);
        fifo_rst_n <= 1'b1;
      end
      repeat (2) @(posedge clk);
      cnt = 0;
      x_e = `AFP_OFFSET_DEFAULT;
      y_e = `AFP_OFFSET_DEFAULT;
      check("flag", flag, 1'b1);
      check("full_n", full_n, 1'b1);
      ahb(1'b0, `AFP_ADDR_OFFSETS, 0, rd);
      check("offsets", rd, {6'h00, y_e, 6'h00, x_e});
      ahb(1'b0, `AFP_ADDR_COUNT, 0, rd);
      check("count", rd, 0);
      ahb(1'b0, `AFP_ADDR_STATE, 0, rd);
      check("state", rd, 32'h0000_0301);
      ahb(1'b0, `AFP_ADDR_STATUS, 0, rd);
      seed = xs(seed);
      v1 = (i == 1) ? 10'h000 : (i == 2) ? 10'h3ff : seed[9:0];
      v2 = (i == 1) ? 10'h3ff : (i == 2) ? 10'h000 : seed[19:10];
      writer_i.prog_offsets(i != 0, v1, v2);
      x_e = v1;
      y_e = (i != 0) ? v2 : v1;
      ahb(1'b0, `AFP_ADDR_STATUS, 0, rd);
      check("programmed", rd & 32'h0000_0002, 32'h0000_0002);
      ahb(1'b0, `AFP_ADDR_OFFSETS, 0, rd);
      check("offsets", rd, {6'h00, y_e, 6'h00, x_e});
      ahb(1'b0, `AFP_ADDR_COUNT, 0, rd);
      check("count", rd, 0);
      step(1'b1, 1'b0);
      // After the first word, enable low must neither program nor block stores
      writer_i.prog_offsets(1'b1, ~v1, ~v2);
      cnt = cnt + 2;
      ahb(1'b0, `AFP_ADDR_OFFSETS, 0, rd);
      check("offsets locked", rd, {6'h00, y_e, 6'h00, x_e});
      ahb(1'b0, `AFP_ADDR_COUNT, 0, rd);
      check("count", rd, 3);
      walk();
    end
    give_verdict();
  end
endmodule : test_fifo_almost_flag_offset_programming
`default_nettype wire
